// ===== rtl/iepb_pkg.sv
package iepb_pkg;
  // Register byte addresses
  localparam logic [7:0] IEPB_ADDR_EN2 = 8'h00;
  localparam logic [7:0] IEPB_ADDR_EN3 = 8'h04;
  localparam logic [7:0] IEPB_ADDR_EN4 = 8'h08;
  localparam logic [7:0] IEPB_ADDR_PR0 = 8'h0c;
  localparam logic [7:0] IEPB_ADDR_PR1 = 8'h10;
  localparam logic [7:0] IEPB_ADDR_PR2 = 8'h14;
  localparam logic [7:0] IEPB_ADDR_FLAG = 8'h18;
  localparam logic [7:0] IEPB_ADDR_MASK = 8'h1c;
  localparam logic [7:0] IEPB_ADDR_LVL = 8'h20;
  // Implemented bit masks
  localparam logic [15:0] IEPB_EN2_MASK = 16'h0007;
  localparam logic [15:0] IEPB_EN3_MASK = 16'h39ff;
  localparam logic [15:0] IEPB_EN4_MASK = 16'h00f6;
  localparam logic [15:0] IEPB_PR_MASK = 16'h7777;
  localparam logic [15:0] IEPB_STAT_MASK = 16'h000f;
  // Reset values
  localparam logic [15:0] IEPB_EN_RST = 16'h0000;
  localparam logic [15:0] IEPB_PR_RST = 16'h4444;
  localparam logic [2:0] IEPB_PRIO_OFF = 3'h0;
  localparam int IEPB_FIELD_W = 4;
  localparam logic [1:0] IEPB_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEPB_RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/iepb_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - An enable bit of one passes its source's request; zero blocks it.
// - Priority code 111 gives level seven, the highest.
// - Code 001 gives level one; other codes give their numeric level.
// - Priority code 000 disables the source regardless of enable.
// - Unimplemented bits read zero and ignore writes.
// - Reset clears enables and loads every priority field with 100.
// - Enable group 3 bits 13,12,11,8,7 map DMA5, codec event/error, CAN B.
// - Enable group 3 bits 6..0 map ext irq, timers, I2C B, timer seven.
// - Enable group 4 bits 7,6,5,4,2,1 implemented; 15..8 unimplemented.
// - Enable group 2 bits 2,1,0 map CAN A rx, SPI B event and error.
// - Priority group 0 fields: timer1, out cmp1, in cap1, ext irq0.
// - Priority group 1 fields: timer2, out cmp2, in cap2, DMA ch0.
// - Priority group 2 fields: UART A rx, SPI A event, error, timer3.
// - A source flag is set when it raised a request; enables gate pending outputs, not flags.
module iepb_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // AXI4-Lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Source requests, same clock, enable-mapped positions
  input wire logic [15:0] i_src_en2,
  input wire logic [15:0] i_src_en3,
  input wire logic [15:0] i_src_en4,
  // Prioritized sources, group 0..2, field order as in the registers
  input wire logic [11:0] i_src_pr,
  // Pending outputs toward the core
  output logic [15:0] o_pend_en2,
  output logic [15:0] o_pend_en3,
  output logic [15:0] o_pend_en4,
  output logic [11:0] o_pend_pr,
  output logic [2:0] o_top_level,
  output logic o_irq
);

  logic [15:0] en2_reg, en3_reg, en4_reg;
  logic [15:0] pr0_reg, pr1_reg, pr2_reg;
  logic [15:0] fen2_reg, fen3_reg, fen4_reg;
  logic [11:0] fpr_reg;
  logic [15:0] mask_reg;
  logic [15:0] sum_flag;
  logic [47:0] pr_all;
  logic [11:0] pr_nz;
  logic [11:0] pend_pr_next;
  logic [2:0] lvl_next;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_wr;
  logic [15:0] wv;
  logic [15:0] rd_next;
  logic rd_hit;

  // Merge with byte strobes; unimplemented bits forced to zero
  function automatic logic [15:0] iepb_merge(input logic [15:0] cur, input logic [15:0] nw,
                                             input logic [3:0] strb, input logic [15:0] msk);
    logic [15:0] r;
    r = cur;
    if (strb[0]) r[7:0] = nw[7:0];
    if (strb[1]) r[15:8] = nw[15:8];
    return r & msk;
  endfunction

  // AXI write channel capture; either order accepted
  assign o_awready = !aw_hold && !o_bvalid;
  assign o_wready = !w_hold && !o_bvalid;
  assign do_wr = aw_hold && w_hold && !o_bvalid;
  assign wv = w_data_reg[15:0];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_bvalid <= 1'b0;
      o_bresp <= iepb_pkg::IEPB_RESP_OKAY;
    end else if (do_wr) begin
      o_bvalid <= 1'b1;
      unique case (aw_addr_reg)
        iepb_pkg::IEPB_ADDR_EN2, iepb_pkg::IEPB_ADDR_EN3, iepb_pkg::IEPB_ADDR_EN4,
        iepb_pkg::IEPB_ADDR_PR0, iepb_pkg::IEPB_ADDR_PR1, iepb_pkg::IEPB_ADDR_PR2,
        iepb_pkg::IEPB_ADDR_FLAG, iepb_pkg::IEPB_ADDR_MASK,
        iepb_pkg::IEPB_ADDR_LVL: o_bresp <= iepb_pkg::IEPB_RESP_OKAY;
        default: o_bresp <= iepb_pkg::IEPB_RESP_SLVERR;
      endcase
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      en2_reg <= iepb_pkg::IEPB_EN_RST;
      en3_reg <= iepb_pkg::IEPB_EN_RST;
      en4_reg <= iepb_pkg::IEPB_EN_RST;
      pr0_reg <= iepb_pkg::IEPB_PR_RST;
      pr1_reg <= iepb_pkg::IEPB_PR_RST;
      pr2_reg <= iepb_pkg::IEPB_PR_RST;
      mask_reg <= 16'h0000;
    end else if (do_wr) begin
      unique case (aw_addr_reg)
        iepb_pkg::IEPB_ADDR_EN2:
          en2_reg <= iepb_merge(en2_reg, wv, w_strb_reg, iepb_pkg::IEPB_EN2_MASK);
        iepb_pkg::IEPB_ADDR_EN3:
          en3_reg <= iepb_merge(en3_reg, wv, w_strb_reg, iepb_pkg::IEPB_EN3_MASK);
        iepb_pkg::IEPB_ADDR_EN4:
          en4_reg <= iepb_merge(en4_reg, wv, w_strb_reg, iepb_pkg::IEPB_EN4_MASK);
        iepb_pkg::IEPB_ADDR_PR0:
          pr0_reg <= iepb_merge(pr0_reg, wv, w_strb_reg, iepb_pkg::IEPB_PR_MASK);
        iepb_pkg::IEPB_ADDR_PR1:
          pr1_reg <= iepb_merge(pr1_reg, wv, w_strb_reg, iepb_pkg::IEPB_PR_MASK);
        iepb_pkg::IEPB_ADDR_PR2:
          pr2_reg <= iepb_merge(pr2_reg, wv, w_strb_reg, iepb_pkg::IEPB_PR_MASK);
        iepb_pkg::IEPB_ADDR_MASK:
          mask_reg <= iepb_merge(mask_reg, wv, w_strb_reg, iepb_pkg::IEPB_STAT_MASK);
        default: ;
      endcase
    end
  end

  // Write-one clear of status; a new request wins over a same-cycle clear
  logic [3:0] clr_stat;
  always_comb begin
    clr_stat = 4'h0;
    if (do_wr && aw_addr_reg == iepb_pkg::IEPB_ADDR_FLAG && w_strb_reg[0]) begin
      clr_stat = wv[3:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      fen2_reg <= 16'h0000;
      fen3_reg <= 16'h0000;
      fen4_reg <= 16'h0000;
      fpr_reg <= 12'h000;
    end else begin
      fen2_reg <= i_src_en2 & iepb_pkg::IEPB_EN2_MASK;
      fen3_reg <= i_src_en3 & iepb_pkg::IEPB_EN3_MASK;
      fen4_reg <= i_src_en4 & iepb_pkg::IEPB_EN4_MASK;
      fpr_reg <= i_src_pr;
    end
  end

  // Priority decode: code value is the level, zero disables
  assign pr_all = {pr2_reg, pr1_reg, pr0_reg};
  always_comb begin
    lvl_next = iepb_pkg::IEPB_PRIO_OFF;
    for (int i = 0; i < 12; i++) begin
      pr_nz[i] = pr_all[i*iepb_pkg::IEPB_FIELD_W +: 3] != iepb_pkg::IEPB_PRIO_OFF;
      pend_pr_next[i] = fpr_reg[i] && pr_nz[i];
      if (pend_pr_next[i] && pr_all[i*iepb_pkg::IEPB_FIELD_W +: 3] > lvl_next)
        lvl_next = pr_all[i*iepb_pkg::IEPB_FIELD_W +: 3];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_pend_en2 <= 16'h0000;
      o_pend_en3 <= 16'h0000;
      o_pend_en4 <= 16'h0000;
      o_pend_pr <= 12'h000;
      o_top_level <= iepb_pkg::IEPB_PRIO_OFF;
    end else begin
      o_pend_en2 <= fen2_reg & en2_reg;
      o_pend_en3 <= fen3_reg & en3_reg;
      o_pend_en4 <= fen4_reg & en4_reg;
      o_pend_pr <= pend_pr_next;
      o_top_level <= lvl_next;
    end
  end

  // Interrupt status: one sticky bit per enable group, one shared by all three priority groups
  logic [15:0] stat_reg;
  logic [3:0] ev;
  assign ev = {|o_pend_pr, |o_pend_en4, |o_pend_en3, |o_pend_en2};
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      stat_reg <= 16'h0000;
    end else begin
      stat_reg <= ((stat_reg & ~{12'h000, clr_stat}) | {12'h000, ev})
                  & iepb_pkg::IEPB_STAT_MASK;
    end
  end
  assign sum_flag = stat_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_irq <= 1'b0;
    else o_irq <= |(sum_flag & mask_reg);
  end

  // Read channel
  assign o_arready = !o_rvalid;
  always_comb begin
    rd_hit = 1'b1;
    unique case (i_araddr)
      iepb_pkg::IEPB_ADDR_EN2: rd_next = en2_reg;
      iepb_pkg::IEPB_ADDR_EN3: rd_next = en3_reg;
      iepb_pkg::IEPB_ADDR_EN4: rd_next = en4_reg;
      iepb_pkg::IEPB_ADDR_PR0: rd_next = pr0_reg;
      iepb_pkg::IEPB_ADDR_PR1: rd_next = pr1_reg;
      iepb_pkg::IEPB_ADDR_PR2: rd_next = pr2_reg;
      iepb_pkg::IEPB_ADDR_FLAG: rd_next = sum_flag;
      iepb_pkg::IEPB_ADDR_MASK: rd_next = mask_reg;
      iepb_pkg::IEPB_ADDR_LVL: rd_next = {13'h0000, o_top_level};
      default: begin
        rd_next = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= iepb_pkg::IEPB_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= {16'h0000, rd_next};
      o_rresp <= rd_hit ? iepb_pkg::IEPB_RESP_OKAY : iepb_pkg::IEPB_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence wr_cfg_s;
    do_wr && aw_addr_reg == iepb_pkg::IEPB_ADDR_EN4;
  endsequence
  sequence irq_cause_s;
    |(sum_flag & mask_reg);
  endsequence
  sequence wr_wait_s;
    o_bvalid && !i_bready;
  endsequence
  sequence rd_wait_s;
    o_rvalid && !i_rready;
  endsequence

  en_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_pend_en3 & ~en3_reg) == 16'h0000 || $changed(en3_reg))
    else $error("pending bit without enable");

  en2_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_pend_en2 & ~en2_reg) == 16'h0000 || $changed(en2_reg))
    else $error("group 2 pending without enable");

  en4_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_pend_en4 & ~en4_reg) == 16'h0000 || $changed(en4_reg))
    else $error("group 4 pending without enable");

  en_block_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !en2_reg[0] |=> !o_pend_en2[0])
    else $error("blocked source pending");

  prio_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    pr0_reg[2:0] == 3'h0 && $stable(pr0_reg) |=> !o_pend_pr[0])
    else $error("disabled source pending");

  prio_top_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fpr_reg[0] && pr0_reg[2:0] == 3'h7 |=> o_top_level == 3'h7)
    else $error("level seven not reported");

  prio_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fpr_reg == 12'h001 && pr0_reg[2:0] == 3'h1 |=> o_top_level == 3'h1)
    else $error("level one not reported");

  lvl_none_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_pend_pr == 12'h000 |-> o_top_level == iepb_pkg::IEPB_PRIO_OFF)
    else $error("level without pending source");

  lvl_some_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_pend_pr != 12'h000 |-> o_top_level != iepb_pkg::IEPB_PRIO_OFF)
    else $error("pending source without level");

  unimpl_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (pr1_reg & ~iepb_pkg::IEPB_PR_MASK) == 16'h0000 && en4_reg[15:8] == 8'h00)
    else $error("unimplemented bit set");

  en2_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (en2_reg & ~iepb_pkg::IEPB_EN2_MASK) == 16'h0000)
    else $error("group 2 unimplemented bit set");

  en3_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (en3_reg & ~iepb_pkg::IEPB_EN3_MASK) == 16'h0000)
    else $error("group 3 unimplemented bit set");

  en4_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (en4_reg & ~iepb_pkg::IEPB_EN4_MASK) == 16'h0000)
    else $error("group 4 unimplemented bit set");

  pr0_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (pr0_reg & ~iepb_pkg::IEPB_PR_MASK) == 16'h0000)
    else $error("priority 0 unimplemented bit set");

  pr2_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (pr2_reg & ~iepb_pkg::IEPB_PR_MASK) == 16'h0000)
    else $error("priority 2 unimplemented bit set");

  reset_val_a: assert property (@(posedge i_ref_clk)
    $rose(i_rstn) |-> pr2_reg == 16'h4444 && en3_reg == 16'h0000)
    else $error("bad reset value");

  en4_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_cfg_s ##0 w_strb_reg[0] |=> en4_reg[7:0] == (wv[7:0] & 8'hf6))
    else $error("enable group 4 write lost");

  dma_five_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fen3_reg[13] && en3_reg[13] |=> o_pend_en3[13])
    else $error("group 3 bit 13 not passed");

  timer_seven_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fen3_reg[0] && en3_reg[0] |=> o_pend_en3[0])
    else $error("group 3 bit 0 not passed");

  pr0_field_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fpr_reg[3] && pr0_reg[14:12] != 3'h0 |=> o_pend_pr[3])
    else $error("priority 0 top field not pending");

  pr1_field_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fpr_reg[4] && pr1_reg[2:0] != 3'h0 |=> o_pend_pr[4])
    else $error("priority 1 low field not pending");

  pr2_field_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fpr_reg[8] && pr2_reg[2:0] != 3'h0 |=> o_pend_pr[8])
    else $error("priority 2 low field not pending");

  flag_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $past(i_rstn) |-> fen2_reg == ($past(i_src_en2) & iepb_pkg::IEPB_EN2_MASK))
    else $error("flag does not follow source");

  stat_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    stat_reg[0] && !clr_stat[0] |=> stat_reg[0])
    else $error("status bit lost");

  stat_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ev[0] |=> stat_reg[0])
    else $error("status set lost to clear");

  pend_path_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_src_en2[2] && en2_reg[2] && $stable(en2_reg) ##1 $stable(en2_reg) |=> o_pend_en2[2])
    else $error("pending missed");

  irq_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    irq_cause_s |=> o_irq)
    else $error("interrupt not raised");

  irq_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(|(sum_flag & mask_reg)) |=> !o_irq)
    else $error("interrupt without cause");

  bresp_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr_wait_s |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");

  rdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    rd_wait_s |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
endmodule

// ===== bench/iepb_src_model.sv
`timescale 1ns/1ps
module iepb_src_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Pattern from the bench
  input wire logic i_load,
  input wire logic [59:0] i_pattern,
  // Source request levels
  output logic [15:0] o_src_en2,
  output logic [15:0] o_src_en3,
  output logic [15:0] o_src_en4,
  output logic [11:0] o_src_pr
);
  // Levels move only just after an edge, as a synchronous peripheral would
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      {o_src_en2, o_src_en3, o_src_en4, o_src_pr} <= 60'h0;
    end else if (i_load) begin
      {o_src_en2, o_src_en3, o_src_en4, o_src_pr} <= i_pattern;
    end
  end
endmodule

// ===== bench/tb_irq_enable_priority_bank.sv
`timescale 1ns/1ps
module tb_irq_enable_priority_bank;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, load = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, v;
  logic [15:0] s2, s3, s4, p2, p3, p4;
  logic [11:0] spr, ppr, epr;
  logic [2:0] lvl;
  logic [59:0] pat = 60'h0;
  logic [15:0] mdl [6];
  logic [15:0] mk [6];
  int mismatches = 0;
  int tests_run = 0;
  int top;

  always #2 clk = ~clk;

  iepb_src_model src_u (.i_ref_clk(clk), .i_rstn(rstn), .i_load(load), .i_pattern(pat),
    .o_src_en2(s2), .o_src_en3(s3), .o_src_en4(s4), .o_src_pr(spr));

  iepb_top dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_src_en2(s2),
    .i_src_en3(s3), .i_src_en4(s4), .i_src_pr(spr), .o_pend_en2(p2), .o_pend_en3(p3),
    .o_pend_en4(p4), .o_pend_pr(ppr), .o_top_level(lvl), .o_irq(irq));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) mismatches++;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) mismatches++;
  endtask

  // Source change, then enough edges for flag, pending, status and irq to land
  task automatic apply(input logic [59:0] p);
    @(posedge clk);
    pat <= p;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic expect_pr();
    top = 0;
    for (int j = 0; j < 12; j++) begin
      epr[j] = spr[j] && (mdl[3 + j / 4][4 * (j % 4) +: 3] != 3'h0);
      if (epr[j] && mdl[3 + j / 4][4 * (j % 4) +: 3] > top) top = mdl[3 + j / 4][4 * (j % 4) +: 3];
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(8220));
    mk = '{iepb_pkg::IEPB_EN2_MASK, iepb_pkg::IEPB_EN3_MASK, iepb_pkg::IEPB_EN4_MASK,
      iepb_pkg::IEPB_PR_MASK, iepb_pkg::IEPB_PR_MASK, iepb_pkg::IEPB_PR_MASK};
    for (int i = 0; i < 6; i++) mdl[i] = (i < 3) ? iepb_pkg::IEPB_EN_RST : iepb_pkg::IEPB_PR_RST;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(4 * i));
      chk(rd, {16'h0, mdl[i]});
    end
    chk({31'h0, irq}, 32'h0);
    // Unmapped place must refuse and leave everything alone
    axi_wr(8'h40, 32'hffff);
    chk({30'h0, rs}, {30'h0, iepb_pkg::IEPB_RESP_SLVERR});
    axi_rd(8'h40);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, iepb_pkg::IEPB_RESP_SLVERR});
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 6; i++) begin
        v = (r == 0) ? 32'hffff_ffff : $urandom;
        axi_wr(8'(4 * i), v);
        chk({30'h0, rs}, {30'h0, iepb_pkg::IEPB_RESP_OKAY});
        mdl[i] = v[15:0] & mk[i];
        axi_rd(8'(4 * i));
        chk(rd, {16'h0, mdl[i]});
        chk({30'h0, rs}, {30'h0, iepb_pkg::IEPB_RESP_OKAY});
      end
    end
    for (int it = 0; it < 8; it++) begin
      for (int i = 0; i < 6; i++) begin
        v = (it == 0) ? ((i < 3) ? 32'hffff : 32'h0701) : $urandom;
        axi_wr(8'(4 * i), v);
        mdl[i] = v[15:0] & mk[i];
      end
      apply(60'({$urandom, $urandom}));
      chk({16'h0, p2}, {16'h0, s2 & mdl[0]});
      chk({16'h0, p3}, {16'h0, s3 & mdl[1]});
      chk({16'h0, p4}, {16'h0, s4 & mdl[2]});
      expect_pr();
      chk({20'h0, ppr}, {20'h0, epr});
      chk({29'h0, lvl}, 32'(top));
      axi_rd(iepb_pkg::IEPB_ADDR_LVL);
      chk(rd, 32'(top));
    end
    // Sticky status, mask and write-one clear
    apply(60'h0);
    axi_wr(iepb_pkg::IEPB_ADDR_MASK, 32'h0);
    axi_wr(iepb_pkg::IEPB_ADDR_FLAG, 32'hf);
    axi_rd(iepb_pkg::IEPB_ADDR_FLAG);
    chk(rd, 32'h0);
    axi_wr(iepb_pkg::IEPB_ADDR_EN2, 32'h1);
    apply(60'h1 << 44);
    axi_rd(iepb_pkg::IEPB_ADDR_FLAG);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    axi_wr(iepb_pkg::IEPB_ADDR_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apply(60'h0);
    chk({31'h0, irq}, 32'h1);
    axi_wr(iepb_pkg::IEPB_ADDR_FLAG, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axi_rd(iepb_pkg::IEPB_ADDR_FLAG);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
